// ==== rtl/frx_pkg.sv ====
package frx_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_OOK_AVG = 8'h16;
  localparam logic [7:0] IDX_RSVD_A = 8'h17;
  localparam logic [7:0] IDX_RSVD_B = 8'h18;
  localparam logic [7:0] IDX_RSVD_C = 8'h19;
  localparam logic [7:0] IDX_AGC_AFC = 8'h1a;
  localparam logic [7:0] IDX_AFC_HI = 8'h1b;
  localparam logic [7:0] IDX_AFC_LO = 8'h1c;
  localparam logic [7:0] IDX_FEI_HI = 8'h1d;
  localparam logic [7:0] IDX_FEI_LO = 8'h1e;
  localparam logic [7:0] IDX_PRE_DET = 8'h1f;
  localparam logic [7:0] IDX_TO_RSSI = 8'h20;
  localparam logic [7:0] IDX_TO_PRE = 8'h21;
  localparam logic [7:0] IDX_TO_SYNC = 8'h22;
  localparam logic [7:0] IDX_RX_DELAY = 8'h23;
  localparam logic [7:0] IDX_OSC = 8'h24;
  localparam int ADDR_LSB = 2;
  // reset values
  localparam logic [7:0] RST_OOK_AVG = 8'h12;
  localparam logic [7:0] RST_RSVD_A = 8'h47;
  localparam logic [7:0] RST_RSVD_B = 8'h32;
  localparam logic [7:0] RST_RSVD_C = 8'h3e;
  localparam logic [7:0] RST_PRE_DET = 8'haa;
  localparam logic [2:0] RST_CLK_SEL = 3'h7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // field positions
  localparam int F_DECAY_HI = 7;
  localparam int F_DECAY_LO = 5;
  localparam int F_OFS_HI = 3;
  localparam int F_OFS_LO = 2;
  localparam int F_FILT_HI = 1;
  localparam int F_FILT_LO = 0;
  localparam int F_AGC_START = 4;
  localparam int F_AFC_RSVD = 3;
  localparam int F_AFC_CLEAR = 1;
  localparam int F_AUTO_CLR = 0;
  localparam int F_PD_EN = 7;
  localparam int F_PD_LEN_HI = 6;
  localparam int F_PD_LEN_LO = 5;
  localparam int F_PD_TOL_HI = 4;
  localparam int F_PD_TOL_LO = 0;
  localparam int F_RC_CAL = 3;
  localparam int F_CLK_HI = 2;
  localparam int F_CLK_LO = 0;
  // timing multipliers: timeout and gap steps in bit periods, sub-ticks per chip
  localparam int TO_BITS_PER_STEP = 16;
  localparam int GAP_BITS_PER_STEP = 4;
  localparam logic [2:0] SUB_TICKS_PER_CHIP = 3'h4;
  typedef enum logic [2:0] {
    FRX_CLK_DIV1 = 3'b000, FRX_CLK_DIV2 = 3'b001, FRX_CLK_DIV4 = 3'b010,
    FRX_CLK_DIV8 = 3'b011, FRX_CLK_DIV16 = 3'b100, FRX_CLK_DIV32 = 3'b101,
    FRX_CLK_RC = 3'b110, FRX_CLK_OFF = 3'b111
  } frx_clk_sel_t;
  typedef enum logic [1:0] {
    FRX_GAP_IDLE = 2'b00, FRX_GAP_COUNT = 2'b01, FRX_GAP_FIRE = 2'b10
  } frx_gap_state_t;
endpackage

// ==== rtl/frx_ctrl_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module frx_ctrl_regs
  import frx_pkg::*;
#(
  parameter int TO_W = 12,
  parameter int GAP_W = 10
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx_mode,
  input wire logic i_rx_enter,
  input wire logic i_bit_tick,
  input wire logic i_chip_tick,
  input wire logic i_sub_tick,
  input wire logic i_agc_phase,
  input wire logic i_level_event,
  input wire logic i_preamble_event,
  input wire logic i_sync_match_event,
  input wire logic i_auto_freq_correction_en,
  input wire logic i_afc_phase_start,
  input wire logic i_freq_correction_load,
  input wire logic [15:0] i_freq_correction_meas,
  input wire logic i_freq_error_load,
  input wire logic [15:0] i_freq_error_meas,
  input wire logic i_restart_request,
  input wire logic i_rc_osc_level,
  output logic o_slicer_decay_strobe,
  output logic [2:0] o_avg_threshold_offset_db,
  output logic [1:0] o_avg_threshold_filter,
  output logic o_gain_sequence_start,
  output logic [15:0] o_freq_correction_value,
  output logic o_preamble_detect_active,
  output logic [1:0] o_preamble_detect_bytes,
  output logic [4:0] o_preamble_chip_tolerance,
  output logic o_level_timeout,
  output logic o_preamble_timeout,
  output logic o_sync_timeout,
  output logic o_restart_launch,
  output logic o_rc_calibration_start,
  output logic o_rc_osc_en,
  output logic o_clock_output_bypass,
  output logic o_clock_output_pin
);

  //////////////////////////////////////////////////////////////////////
  function automatic logic [TO_W-1:0] to_limit(input logic [7:0] v);
    to_limit = TO_W'(v) * TO_W'(TO_BITS_PER_STEP);
  endfunction

  // the reserved size code reports zero bytes, but o_preamble_detect_active ignores the size code
  function automatic logic [1:0] det_bytes(input logic [1:0] len);
    det_bytes = (len == 2'h3) ? 2'h0 : len + 2'h1;
  endfunction

  // offset code steps in units of 2 dB
  function automatic logic [2:0] ofs_db(input logic [1:0] code);
    ofs_db = {code, 1'b0};
  endfunction

  logic [7:0] ook_avg_reg, rsvd_a_reg, rsvd_b_reg, rsvd_c_reg;
  logic agc_rsvd_reg, auto_clr_reg;
  logic [15:0] afc_reg, fei_reg;
  logic [7:0] fei_lo_snap_reg;
  logic [7:0] pre_det_reg;
  logic [7:0] lim_reg [3];
  logic [7:0] gap_reg;
  logic [2:0] clk_sel_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;

  //////////////////////////////////////////////////////////////////////
  // bus decode; one wait state so read data leaves a flip-flop
  wire access_w = i_psel && i_penable;
  wire commit_w = access_w && pready_reg;
  wire [7:0] idx_w = i_paddr[ADDR_LSB+7:ADDR_LSB];
  wire in_map_w = (idx_w >= IDX_OOK_AVG) && (idx_w <= IDX_OSC)
                  && (i_paddr[ADDR_LSB-1:0] == 2'h0)
                  && (i_paddr[31:ADDR_LSB+8] == '0);
  wire wr_w = commit_w && i_pwrite && in_map_w;
  wire rd_hi_fei_w = commit_w && !i_pwrite && in_map_w && (idx_w == IDX_FEI_HI);
  wire [7:0] wb_w = i_pwdata[7:0];
  wire wr_agc_w = wr_w && (idx_w == IDX_AGC_AFC);
  wire wr_osc_w = wr_w && (idx_w == IDX_OSC);
  wire wr_ook_w = wr_w && (idx_w == IDX_OOK_AVG);
  wire wr_pre_w = wr_w && (idx_w == IDX_PRE_DET);

  logic [7:0] rd_mux_w;
  always_comb begin
    case (idx_w)
      IDX_OOK_AVG: rd_mux_w = ook_avg_reg;
      IDX_RSVD_A: rd_mux_w = rsvd_a_reg;
      IDX_RSVD_B: rd_mux_w = rsvd_b_reg;
      IDX_RSVD_C: rd_mux_w = rsvd_c_reg;
      // trigger and clear bits always read zero
      IDX_AGC_AFC: rd_mux_w = {4'h0, agc_rsvd_reg, 2'h0, auto_clr_reg};
      IDX_AFC_HI: rd_mux_w = afc_reg[15:8];
      IDX_AFC_LO: rd_mux_w = afc_reg[7:0];
      IDX_FEI_HI: rd_mux_w = fei_reg[15:8];
      IDX_FEI_LO: rd_mux_w = fei_lo_snap_reg;
      IDX_PRE_DET: rd_mux_w = pre_det_reg;
      IDX_TO_RSSI: rd_mux_w = lim_reg[0];
      IDX_TO_PRE: rd_mux_w = lim_reg[1];
      IDX_TO_SYNC: rd_mux_w = lim_reg[2];
      IDX_RX_DELAY: rd_mux_w = gap_reg;
      IDX_OSC: rd_mux_w = {5'h00, clk_sel_reg};
      default: rd_mux_w = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= access_w && !pready_reg;
      pslverr_reg <= access_w && !pready_reg && !in_map_w;
      prdata_reg <= (access_w && !pready_reg && !i_pwrite && in_map_w)
                    ? {24'h000000, rd_mux_w} : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ook_avg_reg <= RST_OOK_AVG;
      rsvd_a_reg <= RST_RSVD_A;
      rsvd_b_reg <= RST_RSVD_B;
      rsvd_c_reg <= RST_RSVD_C;
      agc_rsvd_reg <= 1'b0;
      auto_clr_reg <= 1'b0;
      pre_det_reg <= RST_PRE_DET;
      for (int i = 0; i < 3; i++) lim_reg[i] <= RST_ZERO;
      gap_reg <= RST_ZERO;
      clk_sel_reg <= RST_CLK_SEL;
    end else if (wr_w) begin
      case (idx_w)
        IDX_OOK_AVG: ook_avg_reg <= wb_w;
        // stored as written; software is expected to leave these alone
        IDX_RSVD_A: rsvd_a_reg <= wb_w;
        IDX_RSVD_B: rsvd_b_reg <= wb_w;
        IDX_RSVD_C: rsvd_c_reg <= wb_w;
        IDX_AGC_AFC: begin
          agc_rsvd_reg <= wb_w[F_AFC_RSVD];
          auto_clr_reg <= wb_w[F_AUTO_CLR];
        end
        IDX_PRE_DET: pre_det_reg <= wb_w;
        IDX_TO_RSSI: lim_reg[0] <= wb_w;
        IDX_TO_PRE: lim_reg[1] <= wb_w;
        IDX_TO_SYNC: lim_reg[2] <= wb_w;
        IDX_RX_DELAY: gap_reg <= wb_w;
        IDX_OSC: clk_sel_reg <= wb_w[F_CLK_HI:F_CLK_LO];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // frequency correction and error words
  wire afc_clr_w = (wr_agc_w && wb_w[F_AFC_CLEAR] && i_rx_mode)
                   || (i_afc_phase_start && i_auto_freq_correction_en && auto_clr_reg);
  logic [15:0] afc_next;
  always_comb begin
    afc_next = afc_reg;
    if (afc_clr_w) afc_next = 16'h0000;
    if (wr_w && idx_w == IDX_AFC_HI) afc_next[15:8] = wb_w;
    if (wr_w && idx_w == IDX_AFC_LO) afc_next[7:0] = wb_w;
    // a fresh measurement wins over any clear in the same cycle
    if (i_freq_correction_load) afc_next = i_freq_correction_meas;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      afc_reg <= 16'h0000;
      fei_reg <= 16'h0000;
      fei_lo_snap_reg <= 8'h00;
    end else begin
      afc_reg <= afc_next;
      if (i_freq_error_load) fei_reg <= i_freq_error_meas;
      // high-byte read freezes the low half so the pair matches
      if (rd_hi_fei_w) fei_lo_snap_reg <= fei_reg[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // slicer threshold decay strobe
  wire [2:0] decay_w = ook_avg_reg[F_DECAY_HI:F_DECAY_LO];
  logic [2:0] chip_cnt_reg;
  logic [3:0] sub_cnt_reg;
  // codes 0-3 count chips, codes 4-7 count quarters of a chip
  wire [2:0] chip_mask_w = 3'((4'h1 << decay_w[1:0]) - 4'h1);
  // codes 4-7 strobe every 8, 4, 2 or 1 sub-ticks, i.e. once per 2 chips up to 4 times per chip
  wire [3:0] sub_mask_w = (4'h8 >> decay_w[1:0]) - 4'h1;
  wire chip_hit_w = i_chip_tick && ((chip_cnt_reg & chip_mask_w) == chip_mask_w);
  wire sub_hit_w = i_sub_tick && ((sub_cnt_reg & sub_mask_w) == sub_mask_w);
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      chip_cnt_reg <= 3'h0;
      sub_cnt_reg <= 4'h0;
      o_slicer_decay_strobe <= 1'b0;
    end else begin
      if (i_chip_tick) chip_cnt_reg <= chip_cnt_reg + 3'h1;
      if (i_sub_tick) sub_cnt_reg <= sub_cnt_reg + 4'h1;
      o_slicer_decay_strobe <= decay_w[2] ? sub_hit_w : chip_hit_w;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive timeouts: 0 level, 1 preamble, 2 sync
  logic [TO_W-1:0] to_cnt_reg [3];
  logic [2:0] to_run_reg, to_fire_reg;
  wire [2:0] to_evt_w = {i_sync_match_event, i_preamble_event, i_level_event};
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      to_run_reg <= 3'h0;
      to_fire_reg <= 3'h0;
      for (int i = 0; i < 3; i++) to_cnt_reg[i] <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        to_fire_reg[i] <= 1'b0;
        if (i_rx_enter) begin
          // a zero limit never arms its counter, so a disabled timeout stays silent
          to_cnt_reg[i] <= '0;
          to_run_reg[i] <= (lim_reg[i] != 8'h00);
        end else if (to_evt_w[i]) begin
          to_run_reg[i] <= 1'b0;
        end else if (to_run_reg[i] && i_bit_tick) begin
          to_cnt_reg[i] <= to_cnt_reg[i] + 1'b1;
          if (to_cnt_reg[i] + 1'b1 == to_limit(lim_reg[i])) begin
            to_fire_reg[i] <= 1'b1;
            to_run_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // automatic restart gap
  frx_gap_state_t gap_st_reg;
  logic [GAP_W-1:0] gap_cnt_reg;
  wire [GAP_W-1:0] gap_lim_w = GAP_W'(gap_reg) * GAP_W'(GAP_BITS_PER_STEP);
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      gap_st_reg <= FRX_GAP_IDLE;
      gap_cnt_reg <= '0;
    end else begin
      case (gap_st_reg)
        FRX_GAP_IDLE: begin
          gap_cnt_reg <= '0;
          if (i_restart_request) begin
            gap_st_reg <= (gap_reg == 8'h00) ? FRX_GAP_FIRE : FRX_GAP_COUNT;
          end
        end
        FRX_GAP_COUNT: begin
          if (i_bit_tick) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
            if (gap_cnt_reg + 1'b1 == gap_lim_w) gap_st_reg <= FRX_GAP_FIRE;
          end
        end
        // a zero gap still passes through here, so every restart is one pulse
        FRX_GAP_FIRE: gap_st_reg <= FRX_GAP_IDLE;
        default: gap_st_reg <= FRX_GAP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // clock output divider and outputs
  logic [4:0] div_reg;
  frx_clk_sel_t sel_w;
  assign sel_w = frx_clk_sel_t'(clk_sel_reg);
  logic pin_next;
  always_comb begin
    case (sel_w)
      FRX_CLK_DIV2: pin_next = div_reg[0];
      FRX_CLK_DIV4: pin_next = div_reg[1];
      FRX_CLK_DIV8: pin_next = div_reg[2];
      FRX_CLK_DIV16: pin_next = div_reg[3];
      FRX_CLK_DIV32: pin_next = div_reg[4];
      FRX_CLK_RC: pin_next = i_rc_osc_level;
      default: pin_next = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      div_reg <= 5'h00;
      o_clock_output_pin <= 1'b0;
      o_clock_output_bypass <= 1'b0;
      o_rc_osc_en <= 1'b0;
      o_rc_calibration_start <= 1'b0;
      o_gain_sequence_start <= 1'b0;
      o_restart_launch <= 1'b0;
      o_preamble_detect_active <= 1'b0;
    end else begin
      div_reg <= div_reg + 5'h01;
      // a full-rate clock cannot come from a flip-flop; the pad mux takes it
      o_clock_output_bypass <= (sel_w == FRX_CLK_DIV1);
      o_clock_output_pin <= pin_next;
      o_rc_osc_en <= (sel_w == FRX_CLK_RC);
      o_rc_calibration_start <= wr_osc_w && wb_w[F_RC_CAL];
      o_gain_sequence_start <= wr_agc_w && wb_w[F_AGC_START];
      o_restart_launch <= (gap_st_reg == FRX_GAP_FIRE);
      o_preamble_detect_active <= pre_det_reg[F_PD_EN] && !i_agc_phase;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // decoded fields are flopped from the write data so they move with their register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_avg_threshold_offset_db <= ofs_db(RST_OOK_AVG[F_OFS_HI:F_OFS_LO]);
      o_preamble_detect_bytes <= det_bytes(RST_PRE_DET[F_PD_LEN_HI:F_PD_LEN_LO]);
    end else begin
      if (wr_ook_w) o_avg_threshold_offset_db <= ofs_db(wb_w[F_OFS_HI:F_OFS_LO]);
      if (wr_pre_w) o_preamble_detect_bytes <= det_bytes(wb_w[F_PD_LEN_HI:F_PD_LEN_LO]);
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_freq_correction_value = afc_reg;
  assign o_level_timeout = to_fire_reg[0];
  assign o_preamble_timeout = to_fire_reg[1];
  assign o_sync_timeout = to_fire_reg[2];
  assign o_avg_threshold_filter = ook_avg_reg[F_FILT_HI:F_FILT_LO];
  assign o_preamble_chip_tolerance = pre_det_reg[F_PD_TOL_HI:F_PD_TOL_LO];
endmodule
`default_nettype wire

// ==== tb/frx_ctrl_regs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module frx_ctrl_regs_sva (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_rx_mode,
  input wire logic i_bit_tick,
  input wire logic i_agc_phase,
  input wire logic i_freq_correction_load,
  input wire logic [15:0] o_freq_correction_value,
  input wire logic o_gain_sequence_start,
  input wire logic o_preamble_detect_active,
  input wire logic o_level_timeout,
  input wire logic o_rc_calibration_start,
  input wire logic o_clock_output_bypass,
  input wire logic o_clock_output_pin
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // a write commits only at the edge where the slave answers
  wire wr = i_psel && i_penable && o_pready && i_pwrite;
  ready_timing_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("ready did not follow the access cycle");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data not zero outside answer");
  gain_start_a: assert property (o_gain_sequence_start |-> $past(wr && i_paddr == 32'h68 && i_pwdata[4]))
    else $error("gain start without trigger write");
  rc_start_a: assert property (wr && i_paddr == 32'h90 && i_pwdata[3] |=> o_rc_calibration_start)
    else $error("calibration start missing");
  afc_clear_a: assert property (wr && i_paddr == 32'h68 && i_pwdata[1] && i_rx_mode && !i_freq_correction_load
    |=> o_freq_correction_value == 16'h0) else $error("correction not cleared");
  detect_gate_a: assert property (o_preamble_detect_active |-> !$past(i_agc_phase))
    else $error("detector active during gain phase");
  level_tick_a: assert property (o_level_timeout |-> $past(i_bit_tick))
    else $error("timeout not after a bit tick");
  bypass_pin_a: assert property (o_clock_output_bypass && $past(o_clock_output_bypass) |-> !o_clock_output_pin)
    else $error("pin driven while bypassed");
endmodule
bind frx_ctrl_regs frx_ctrl_regs_sva u_sva (.*);
`default_nettype wire

// ==== tb/frx_ctrl_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module frx_ctrl_regs_test;
  logic i_mclk = '0, i_sys_rst = '1, i_psel = '0, i_penable = '0, i_pwrite = '0, er;
  logic [31:0] i_paddr = '0, i_pwdata = '0, o_prdata, rd;
  logic i_rx_mode = '0, i_rx_enter = '0, i_bit_tick = '0, i_chip_tick = '0, i_sub_tick = '0;
  logic i_agc_phase = '0, i_level_event = '0, i_preamble_event = '0, i_sync_match_event = '0;
  logic i_auto_freq_correction_en = '0, i_afc_phase_start = '0, i_freq_correction_load = '0;
  logic i_freq_error_load = '0, i_restart_request = '0, i_rc_osc_level = '0;
  logic [15:0] i_freq_correction_meas = '0, i_freq_error_meas = '0, o_freq_correction_value;
  logic o_pready, o_pslverr, o_slicer_decay_strobe, o_gain_sequence_start, o_preamble_detect_active;
  logic o_level_timeout, o_preamble_timeout, o_sync_timeout, o_restart_launch, o_rc_calibration_start;
  logic o_rc_osc_en, o_clock_output_bypass, o_clock_output_pin;
  logic [2:0] o_avg_threshold_offset_db;
  logic [1:0] o_avg_threshold_filter, o_preamble_detect_bytes;
  logic [4:0] o_preamble_chip_tolerance;
  int err_total = 0, n_checks = 0, cyc = 0, k = 0, ns = 0, t_lvl, t_pre, t_syn, t_rs;
  frx_ctrl_regs u_dut (.*);
  always #50 i_mclk = ~i_mclk;
  ////////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    i_rc_osc_level <= cyc[2];
    ns += o_slicer_decay_strobe;
    if (o_level_timeout) t_lvl = k;
    if (o_preamble_timeout) t_pre = k;
    if (o_sync_timeout) t_syn = k;
    if (o_restart_launch) t_rs = k;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // starts on an edge; ends one step after the commit edge so next-cycle pulses are visible
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    do @(posedge i_mclk); while (o_pready !== 1'h1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // one tick every three cycles keeps the sampled count stable
  task automatic tick(input int b, input int c, input int s, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      i_bit_tick <= b[0];
      i_chip_tick <= c[0];
      i_sub_tick <= s[0];
      i_preamble_event <= 1'h0;
      k <= k + 1;
      @(posedge i_mclk);
      i_bit_tick <= 1'h0;
      i_chip_tick <= 1'h0;
      i_sub_tick <= 1'h0;
      @(posedge i_mclk);
    end
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic [7:0] ev[15] = '{8'h12, 8'h47, 8'h32, 8'h3e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'haa, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h07};
    for (int j = 0; j < 15; j++)
      if (j != 7 && j != 8) rdchk("reset value", (j + 32'h16) * 4, {24'h0, ev[j]});
    chk("filter", 2, o_avg_threshold_filter);
    chk("detect bytes", 2, o_preamble_detect_bytes);
    chk("tolerance", 32'h0a, o_preamble_chip_tolerance);
    chk("clock pin", 0, o_clock_output_pin);
    rdchk("unmapped data", 32'h94, 32'h0);
    chk("unmapped error", 1, er);
  endtask
  task automatic t_fields();
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, 32'h58, 32'h10 | i << 2 | i);
      chk("offset db", 2 * i, o_avg_threshold_offset_db);
      chk("filter", i, o_avg_threshold_filter);
      apb(1'h1, 32'h7c, 32'h80 | i << 5 | i + 5);
      chk("detect bytes", i == 3 ? 0 : i + 1, o_preamble_detect_bytes);
      chk("tolerance", i + 5, o_preamble_chip_tolerance);
    end
    @(posedge i_mclk);
    i_agc_phase <= 1'h1;
    repeat (2) @(posedge i_mclk);
    #1 chk("detect in gain phase", 0, o_preamble_detect_active);
    @(posedge i_mclk);
    i_agc_phase <= 1'h0;
    repeat (2) @(posedge i_mclk);
    #1 chk("detect enabled", 1, o_preamble_detect_active);
  endtask
  task automatic t_decay();
    for (int c = 0; c < 8; c++) begin
      apb(1'h1, 32'h58, c << 5 | 32'h12);
      ns = 0;
      tick(0, c < 4, c >= 4, 16);
      chk("decay strobes", c < 4 ? 16 >> c : 2 << (c - 4), ns);
    end
  endtask
  task automatic t_trig();
    int tg;
    logic p;
    apb(1'h1, 32'h68, 32'h13);
    chk("gain start", 1, o_gain_sequence_start);
    rdchk("trigger bits read", 32'h68, 32'h01);
    for (int s = 0; s < 8; s++) begin
      apb(1'h1, 32'h90, 32'h8 | s);
      chk("calibration start", 1, o_rc_calibration_start);
      // the new select reaches the flopped outputs one edge after the commit
      repeat (2) @(posedge i_mclk);
      chk("bypass", s == 0, o_clock_output_bypass);
      chk("rc enable", s == 6, o_rc_osc_en);
      tg = 0;
      p = o_clock_output_pin;
      repeat (64) begin
        @(posedge i_mclk);
        tg += (o_clock_output_pin !== p);
        p = o_clock_output_pin;
      end
      chk("pin toggles", s > 0 && s < 6 ? 128 >> s : (s == 6 ? 16 : 0), tg);
      rdchk("osc readback", 32'h90, s);
    end
  endtask
  task automatic pulse_afc();
    @(posedge i_mclk);
    i_afc_phase_start <= 1'h1;
    @(posedge i_mclk);
    i_afc_phase_start <= 1'h0;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic t_afc();
    apb(1'h1, 32'h6c, 32'h12);
    apb(1'h1, 32'h70, 32'h34);
    chk("correction", 16'h1234, o_freq_correction_value);
    apb(1'h1, 32'h68, 32'h2);
    chk("clear outside receive", 16'h1234, o_freq_correction_value);
    @(posedge i_mclk);
    i_rx_mode <= 1'h1;
    apb(1'h1, 32'h68, 32'h2);
    chk("clear in receive", 0, o_freq_correction_value);
    apb(1'h1, 32'h6c, 32'h80);
    @(posedge i_mclk);
    i_auto_freq_correction_en <= 1'h1;
    pulse_afc();
    chk("kept without auto clear", 16'h8000, o_freq_correction_value);
    apb(1'h1, 32'h68, 32'h1);
    pulse_afc();
    chk("auto clear", 0, o_freq_correction_value);
    @(posedge i_mclk);
    i_freq_error_meas <= 16'hbeef;
    i_freq_error_load <= 1'h1;
    i_freq_correction_meas <= 16'hc3a5;
    i_freq_correction_load <= 1'h1;
    @(posedge i_mclk);
    i_freq_error_load <= 1'h0;
    i_freq_correction_load <= 1'h0;
    #1 chk("loaded correction", 16'hc3a5, o_freq_correction_value);
    rdchk("error high", 32'h74, 32'hbe);
    rdchk("error low", 32'h78, 32'hef);
  endtask
  task automatic rx_run(input logic pe, input int n);
    t_lvl = 0;
    t_pre = 0;
    t_syn = 0;
    t_rs = 0;
    @(posedge i_mclk);
    i_rx_enter <= 1'h1;
    i_restart_request <= 1'h1;
    k <= 0;
    @(posedge i_mclk);
    i_rx_enter <= 1'h0;
    i_restart_request <= 1'h0;
    i_preamble_event <= pe;
    tick(1, 0, 0, n);
  endtask
  task automatic t_timeout();
    apb(1'h1, 32'h80, 32'h1);
    apb(1'h1, 32'h84, 32'h1);
    apb(1'h1, 32'h88, 32'h2);
    apb(1'h1, 32'h8c, 32'h2);
    rx_run(1'h1, 40);
    chk("level timeout", 16, t_lvl);
    chk("preamble stopped", 0, t_pre);
    chk("sync timeout", 32, t_syn);
    chk("restart gap", 8, t_rs);
    apb(1'h1, 32'h80, 32'h0);
    rx_run(1'h0, 20);
    chk("level disabled", 0, t_lvl);
    chk("preamble timeout", 16, t_pre);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_mclk);
    i_sys_rst <= 1'h0;
    @(posedge i_mclk);
    t_defaults();
    t_fields();
    t_decay();
    t_trig();
    t_afc();
    t_timeout();
    final_report();
  end
endmodule
`default_nettype wire
